// File: common/lcdc_pkg.sv
// Package: register map, field layout and reset values of the LCD clock output controller
//
// Functional notes
// - Reset clears the selection register to zero: output off, no source.
// - Selection register at FF40H; enable at bit 4, source select bits 3..0.
// - Clock drives out only when enable is 1 and port gate bit is 0.
// - Select 0110 gives fprs/64, 0111 fprs/128, 1000 subsystem clock; others prohibited.
// - Both registers take single-bit and eight-bit writes; other bits stay unchanged.
// - Reset sets the port direction register to FFH, gating the output off.
// - Output gating never emits a truncated narrow pulse on enable changes that keep a valid source selected.
// - Start output during a low phase; stop after a full high phase unless a prohibited source is selected.
package lcdc_pkg;

	localparam logic [15:0] LCDC_SEL_ADDR    = 16'hff40;
	localparam logic [15:0] LCDC_PDIR_ADDR   = 16'hff2e;
	localparam logic [7:0]  LCDC_SEL_RESET   = 8'h00;
	localparam logic [7:0]  LCDC_PDIR_RESET  = 8'hff;
	localparam int          LCDC_ENABLE_BIT  = 4;
	localparam int          LCDC_SRC_LSB     = 0;
	localparam int          LCDC_SRC_W       = 4;
	localparam int          LCDC_GATE_BIT    = 0;
	localparam logic [3:0]  LCDC_SRC_DIV64   = 4'h6;
	localparam logic [3:0]  LCDC_SRC_DIV128  = 4'h7;
	localparam logic [3:0]  LCDC_SRC_SUB     = 4'h8;
	localparam int          LCDC_DIV_W       = 7;
	localparam logic [7:0]  LCDC_SEL_WMASK   = 8'h1f;
	// Core cycles of one high phase of the divide-by-64 source
	localparam int          LCDC_DIV64_HIGH  = 32;

	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic        bit_op;
		logic [2:0]  bit_idx;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} lcdc_req_t;

endpackage

// File: rtl/lcdc_clock_out.sv
// LCD clock output controller: registers, source select and glitch-free output gate
`timescale 1ns/1ps
module lcdc_clock_out
	import lcdc_pkg::*;
#(
	parameter int DIV_W = LCDC_DIV_W
)
(
	input  wire logic      core_clk,
	input  wire logic      rst_n,
	input  wire lcdc_req_t req,
	output logic [7:0]     rdata,
	input  wire logic      fsub_pin,
	output logic           lcd_clk
);

	initial
	begin
		if (DIV_W < 7)
			$error("DIV_W must be at least 7 for the divide-by-128 tap");
	end

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] clock_output_select;
	logic [7:0] port14_direction;
	logic [7:0] next_sel;
	logic [7:0] next_pdir;

	always_comb
	begin
		next_sel  = clock_output_select;
		next_pdir = port14_direction;
		if (req.wr && req.addr == LCDC_SEL_ADDR)
		begin
			if (req.bit_op)
				next_sel[req.bit_idx] = req.wdata[0];
			else
				next_sel = req.wdata;
			// Upper bits are hard zero so a stray write cannot set them
			next_sel = next_sel & LCDC_SEL_WMASK;
		end
		if (req.wr && req.addr == LCDC_PDIR_ADDR)
		begin
			if (req.bit_op)
				next_pdir[req.bit_idx] = req.wdata[0];
			else
				next_pdir = req.wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clock_output_select <= LCDC_SEL_RESET;
			port14_direction    <= LCDC_PDIR_RESET;
		end
		else
		begin
			clock_output_select <= next_sel;
			port14_direction    <= next_pdir;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (req.rd && req.addr == LCDC_SEL_ADDR)
			rdata <= clock_output_select;
		else if (req.rd && req.addr == LCDC_PDIR_ADDR)
			rdata <= port14_direction;
		else
			rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Sources

	logic [DIV_W-1:0] prescale;
	logic             fsub_meta;
	logic             fsub_sync;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			prescale <= '0;
		else
			prescale <= prescale + 1'b1;
	end

	// Subsystem clock is asynchronous; resynchronise before use
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fsub_meta <= 1'b0;
			fsub_sync <= 1'b0;
		end
		else
		begin
			fsub_meta <= fsub_pin;
			fsub_sync <= fsub_meta;
		end
	end

	logic [3:0] clk_source_select;
	logic       clk_out_enable;
	logic       port_output_gate_bit;
	logic       src_clk;
	logic       src_valid;

	assign clk_source_select    = clock_output_select[LCDC_SRC_LSB +: LCDC_SRC_W];
	assign clk_out_enable       = clock_output_select[LCDC_ENABLE_BIT];
	assign port_output_gate_bit = port14_direction[LCDC_GATE_BIT];

	always_comb
	begin
		src_clk   = 1'b0;
		src_valid = 1'b1;
		case (clk_source_select)
			LCDC_SRC_DIV64:  src_clk = prescale[5];
			LCDC_SRC_DIV128: src_clk = prescale[6];
			LCDC_SRC_SUB:    src_clk = fsub_sync;
			default:         src_valid = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Output gate

	logic want_on;
	logic gate_on;
	logic src_prev;

	assign want_on = clk_out_enable && !port_output_gate_bit && src_valid;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			src_prev <= 1'b0;
		else
			src_prev <= src_clk;
	end

	// close at once on a prohibited source, else switch after a falling edge, so start is low and stop follows full high
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			gate_on <= 1'b0;
		else if (!want_on && !src_valid)
			gate_on <= 1'b0;
		else if (src_prev && !src_clk)
			gate_on <= want_on;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			lcd_clk <= 1'b0;
		else
			lcd_clk <= gate_on & src_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Check helpers

	// Length of the running high phase, saturating so a stuck output cannot wrap it
	logic [7:0] high_cnt;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			high_cnt <= 8'h00;
		else if (!lcd_clk)
			high_cnt <= 8'h00;
		else if (high_cnt != 8'hff)
			high_cnt <= high_cnt + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_reg_sel_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req.wr && !req.bit_op && req.addr == LCDC_SEL_ADDR)
			|=> clock_output_select == ($past(req.wdata) & LCDC_SEL_WMASK))
		else $error("selection register byte write lost");

	a_bit_keep_others: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req.wr && req.bit_op && req.addr == LCDC_PDIR_ADDR)
			|=> ((port14_direction ^ $past(port14_direction)) & ~(8'h01 << $past(req.bit_idx))) == 8'h00)
		else $error("bit write disturbed other bits");

	a_off_static_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!want_on && !gate_on) ##1 !gate_on |-> !lcd_clk)
		else $error("clock output active while disabled");

	a_prohibited_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		!src_valid ##1 !src_valid |-> !lcd_clk)
		else $error("prohibited source produced output");

	a_start_low_phase: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(gate_on) && src_valid |-> !src_clk)
		else $error("output started outside low phase");

	a_stop_after_high: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(gate_on) && src_valid |-> !src_clk)
		else $error("output stopped inside high phase");

	a_no_short_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(lcd_clk) && clk_source_select == LCDC_SRC_DIV64 && $stable(clock_output_select)
			|-> lcd_clk[*8])
		else $error("narrow pulse on clock output");

	a_read_data: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req.rd && req.addr == LCDC_SEL_ADDR) |=> rdata == $past(clock_output_select))
		else $error("selection register read mismatch");

	a_sel_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clock_output_select & ~LCDC_SEL_WMASK) == 8'h00)
		else $error("selection register upper bits set");

	a_sel_bit_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req.wr && req.bit_op && req.addr == LCDC_SEL_ADDR)
			|=> ((clock_output_select ^ $past(clock_output_select)) & ~(8'h01 << $past(req.bit_idx))) == 8'h00)
		else $error("selection bit write disturbed other bits");

	a_pdir_byte_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req.wr && !req.bit_op && req.addr == LCDC_PDIR_ADDR) |=> port14_direction == $past(req.wdata))
		else $error("direction register byte write lost");

	a_sel_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(req.wr && req.addr == LCDC_SEL_ADDR) |=> $stable(clock_output_select))
		else $error("selection register changed without a write");

	a_pdir_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(req.wr && req.addr == LCDC_PDIR_ADDR) |=> $stable(port14_direction))
		else $error("direction register changed without a write");

	a_read_pdir: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req.rd && req.addr == LCDC_PDIR_ADDR) |=> rdata == $past(port14_direction))
		else $error("direction register read mismatch");

	a_read_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(req.rd && (req.addr == LCDC_SEL_ADDR || req.addr == LCDC_PDIR_ADDR)) |=> rdata == 8'h00)
		else $error("read data not zero outside a read");

	a_gate_opens_wanted: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(gate_on) |-> $past(want_on))
		else $error("gate opened without enable");

	a_out_needs_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		lcd_clk |-> $past(gate_on))
		else $error("output high with gate closed");

	a_gate_closed_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		!gate_on |=> !lcd_clk)
		else $error("output high after gate closed");

	a_invalid_closes: assert property (@(posedge core_clk) disable iff (!rst_n)
		!src_valid |=> !gate_on)
		else $error("gate open on prohibited source");

	a_prescale_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n) |-> prescale == DIV_W'($past(prescale) + 1'b1))
		else $error("prescaler did not advance");

	a_sync_chain: assert property (@(posedge core_clk) disable iff (!rst_n)
		fsub_sync == $past(fsub_meta))
		else $error("subsystem clock synchroniser broken");

	a_full_high: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(lcd_clk) && clk_source_select == LCDC_SRC_DIV64 |-> high_cnt >= 8'(LCDC_DIV64_HIGH))
		else $error("high phase cut short");

endmodule

// File: verif/lcdc_clock_out_test.sv
// Self-checking bench for the LCD clock output controller
`timescale 1ns/1ps
module lcdc_clock_out_test import lcdc_pkg::*;;
	logic       core_clk, rst_n, fsub_pin, lcd_clk, narrow, rd_d;
	lcdc_req_t  req;
	logic [7:0] rdata, d;
	logic [7:0] q [$];
	int         fail_count, num_checks, seed, i;
	logic [7:0] codes [3] = '{8'h06, 8'h07, 8'h08};
	int         per_exp [3] = '{64, 128, 200};
	logic [7:0] pd [3] = '{8'hff, 8'hfe, 8'hfe};
	logic [7:0] sc [3] = '{8'h06, 8'h05, 8'h0f};
	lcdc_clock_out uut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
		.fsub_pin(fsub_pin), .lcd_clk(lcd_clk));
	lcdc_lcd_model far (.lcd_clk(lcd_clk), .fsub_pin(fsub_pin), .narrow(narrow));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Read data is the expected value when r is set
	task automatic op(input logic w, input logic r, input logic b, input logic [2:0] x,
		input logic [15:0] a, input logic [7:0] v);
		@(posedge core_clk);
		req <= '{w, r, b, x, a, v};
		if (r)
			q.push_back(v);
		@(posedge core_clk);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
	endtask
	task automatic per(input int e);
		int n;
		for (n = 0; lcd_clk !== 1'b0 && n < 999; n++) @(negedge core_clk);
		for (n = 0; lcd_clk !== 1'b1 && n < 999; n++) @(negedge core_clk);
		for (n = 0; lcd_clk !== 1'b0 && n < 999; n++) @(negedge core_clk);
		for (; lcd_clk !== 1'b1 && n < 999; n++) @(negedge core_clk);
		chk("period", e, n);
	endtask
	// Lets a running high phase finish before watching for silence
	task automatic low(input int k);
		logic h;
		h = 1'b0;
		repeat (210) @(negedge core_clk);
		repeat (k) @(negedge core_clk) h = h | lcd_clk;
		chk("lcd_clk", 16'h0, {15'h0, h});
	endtask
	always @(posedge core_clk)
	begin
		rd_d <= req.rd;
		if (rd_d === 1'b1 && q.size() > 0)
			chk("rdata", {8'h0, q.pop_front()}, {8'h0, rdata});
	end
	initial
	begin
		#200us;
		fail_count++;
		summarize();
	end
	initial
	begin
		req = '0;
		rst_n = 1'b0;
		rd_d = 1'b0;
		seed = 41333;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		op(0, 1, 0, 0, LCDC_SEL_ADDR, 8'h00);
		op(0, 1, 0, 0, LCDC_PDIR_ADDR, 8'hff);
		op(0, 1, 0, 0, 16'hff41, 8'h00);
		$display("reset test done");
		for (i = 0; i < 4; i++)
		begin
			d = $random(seed);
			op(1, 0, 0, 0, LCDC_PDIR_ADDR, d);
			op(0, 1, 0, 0, LCDC_PDIR_ADDR, d);
		end
		op(1, 0, 0, 0, LCDC_PDIR_ADDR, 8'hff);
		op(1, 0, 1, 0, LCDC_PDIR_ADDR, 8'h00);
		op(0, 1, 0, 0, LCDC_PDIR_ADDR, 8'hfe);
		$display("register test done");
		for (i = 0; i < 3; i++)
		begin
			op(1, 0, 0, 0, LCDC_SEL_ADDR, codes[i]);
			op(1, 0, 1, 4, LCDC_SEL_ADDR, 8'h01);
			op(0, 1, 0, 0, LCDC_SEL_ADDR, codes[i] | 8'h10);
			per(per_exp[i]);
			op(1, 0, 1, 4, LCDC_SEL_ADDR, 8'h00);
			low(300);
		end
		$display("source test done");
		for (i = 0; i < 3; i++)
		begin
			op(1, 0, 0, 0, LCDC_PDIR_ADDR, pd[i]);
			op(1, 0, 0, 0, LCDC_SEL_ADDR, sc[i]);
			op(1, 0, 0, 0, LCDC_SEL_ADDR, sc[i] | 8'h10);
			low(300);
			op(1, 0, 0, 0, LCDC_SEL_ADDR, sc[i]);
		end
		$display("gate test done");
		chk("narrow", 16'h0, {15'h0, narrow});
		summarize();
	end
endmodule

// File: verif/lcdc_lcd_model.sv
// Far-side model: subsystem clock source and LCD clock input watcher
`timescale 1ns/1ps
module lcdc_lcd_model
(
	input  wire logic lcd_clk,
	output logic      fsub_pin,
	output logic      narrow
);
	// Far in the past so the reset settling of the line is not taken for a pulse
	realtime t_rise = -1.0e6;
	initial
	begin
		fsub_pin = 1'b0;
		narrow = 1'b0;
		#3;
		forever #1000 fsub_pin = ~fsub_pin;
	end
	always @(posedge lcd_clk) t_rise = $realtime;
	always @(negedge lcd_clk) if ($realtime - t_rise < 300.0) narrow = 1'b1;
endmodule
